/* inc/dbo_regs.vh */
// constants for the burst order and extended config word one block
`ifndef DBO_REGS_VH
`define DBO_REGS_VH
// ---------------------------------------------
// config word fields
// ---------------------------------------------
`define DBO_ADDR_W 14
`define DBO_BIT_DLL_OFF 0
`define DBO_BIT_DRIVE 1
`define DBO_BIT_RTT_LO 2
`define DBO_AL_LO 3
`define DBO_AL_HI 5
`define DBO_BIT_RTT_HI 6
`define DBO_CAL_LO 7
`define DBO_CAL_HI 9
`define DBO_BIT_STROBE_N_OFF 10
`define DBO_BIT_XSTROBE 11
`define DBO_BIT_OUT_OFF 12
`define DBO_AL_RESERVED 3'h7
`define DBO_CAL_EXIT 3'h0
`define DBO_CAL_DEFAULT 3'h7
`define DBO_WORD_RESET 14'h0000
// ---------------------------------------------
// command encodings {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------
`define DBO_CMD_MRS 4'h0
`define DBO_CMD_REF 4'h1
`define DBO_BA_EXT1 2'h1
// ---------------------------------------------
// burst settings
// ---------------------------------------------
`define DBO_BL4 1'h0
`define DBO_BL8 1'h1
`define DBO_SEQ 1'h0
`define DBO_ILV 1'h1
`endif

/* hw/dbo_sync.v */
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module dbo_sync #(
	parameter W = 1
) (
	input wire i_core_clk,
	input wire i_rst,
	input wire [W-1:0] i_d,
	output reg [W-1:0] o_q
);
	reg [W-1:0] meta;
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			meta <= {W{1'b0}};
			o_q <= {W{1'b0}};
		end else begin
			meta <= i_d;
			o_q <= meta;
		end
	end
endmodule

/* hw/dbo_order.v */
// burst column order generator
`timescale 1ns/10ps
`include "dbo_regs.vh"
module dbo_order (
	input wire i_len8,
	input wire i_ilv,
	input wire [2:0] i_start,
	input wire [2:0] i_beat,
	output wire [2:0] o_col
);
	function [2:0] dbo_next_col;
		input len8;
		input ilv;
		input [2:0] s;
		input [2:0] b;
		reg [1:0] low;
		begin
			low = s[1:0] + b[1:0];
			if (ilv == `DBO_ILV) begin
				dbo_next_col = s ^ b;
			end else begin
				dbo_next_col = {s[2] ^ b[2], low};
			end
			if (len8 == `DBO_BL4) begin
				// bit two passes through unchanged in 4-beat bursts
				dbo_next_col[2] = s[2];
				dbo_next_col[1:0] = (ilv == `DBO_ILV) ?
					(s[1:0] ^ b[1:0]) : low;
			end
		end
	endfunction
	assign o_col = dbo_next_col(i_len8, i_ilv, i_start, i_beat);
endmodule

/* hw/dbo_top.v */
// burst ordering and extended config word one of the memory device
//
`timescale 1ns/10ps
`include "dbo_regs.vh"
module dbo_top (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_link_clk,
	input wire i_cke,
	input wire i_cs_n,
	input wire i_ras_n,
	input wire i_cas_n,
	input wire i_we_n,
	input wire [1:0] i_ba,
	input wire [`DBO_ADDR_W-1:0] i_addr,
	input wire i_burst_start,
	input wire i_len8,
	input wire i_ilv,
	input wire [2:0] i_start_col,
	output reg [2:0] o_col,
	output reg o_col_valid,
	output reg [`DBO_ADDR_W-1:0] o_config_word,
	output reg o_config_loaded,
	output reg o_dll_on,
	output reg o_self_refresh,
	output reg o_drive_reduced,
	output reg [2:0] o_additive_latency,
	output reg o_al_reserved,
	output reg [1:0] o_termination,
	output reg o_strobe_n_off,
	output reg o_extra_read_strobe,
	output reg [2:0] o_driver_calibration_program,
	output reg o_cal_reserved,
	output reg o_outputs_off
);
	// ---------------------------------------------
	// pin synchronisation
	// ---------------------------------------------
	// pins are sampled on link clock rising edges found by the core clock;
	// the pin clock must stay well below half the core rate
	wire [`DBO_ADDR_W+6:0] pins_s;
	wire link_clk_s;
	reg link_clk_d;
	dbo_sync #(.W(1)) u_clk_sync (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_d(i_link_clk),
		.o_q(link_clk_s)
	);
	dbo_sync #(.W(`DBO_ADDR_W+7)) u_pin_sync (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_d({i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr}),
		.o_q(pins_s)
	);
	wire cke_s = pins_s[`DBO_ADDR_W+6];
	wire [3:0] cmd_s = pins_s[`DBO_ADDR_W+5:`DBO_ADDR_W+2];
	wire [1:0] ba_s = pins_s[`DBO_ADDR_W+1:`DBO_ADDR_W];
	wire [`DBO_ADDR_W-1:0] addr_s = pins_s[`DBO_ADDR_W-1:0];
	wire link_rise = link_clk_s & ~link_clk_d;
	reg cke_prev;

	// ---------------------------------------------
	// command decode
	// ---------------------------------------------
	wire mrs_ext1 = link_rise & cke_prev & cke_s &
		(cmd_s == `DBO_CMD_MRS) & (ba_s == `DBO_BA_EXT1);
	wire sr_entry = link_rise & cke_prev & ~cke_s &
		(cmd_s == `DBO_CMD_REF);
	wire sr_exit = link_rise & ~cke_prev & cke_s & o_self_refresh;

	// ---------------------------------------------
	// config word and decoded fields
	// ---------------------------------------------
	// bank state is the controller's duty, so no precharge check here
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			link_clk_d <= 1'b0;
			cke_prev <= 1'b0;
			o_config_word <= `DBO_WORD_RESET;
			o_config_loaded <= 1'b0;
			o_self_refresh <= 1'b0;
			o_dll_on <= 1'b0;
			o_drive_reduced <= 1'b0;
			o_additive_latency <= 3'h0;
			o_al_reserved <= 1'b0;
			o_termination <= 2'h0;
			o_strobe_n_off <= 1'b0;
			o_extra_read_strobe <= 1'b0;
			o_driver_calibration_program <= `DBO_CAL_EXIT;
			o_cal_reserved <= 1'b0;
			o_outputs_off <= 1'b0;
		end else begin
			link_clk_d <= link_clk_s;
			if (link_rise) begin
				cke_prev <= cke_s;
			end
			if (mrs_ext1) begin
				o_config_word <= addr_s;
				o_config_loaded <= 1'b1;
				o_dll_on <= ~addr_s[`DBO_BIT_DLL_OFF] &
					~o_self_refresh;
				o_drive_reduced <= addr_s[`DBO_BIT_DRIVE];
				o_additive_latency <=
					addr_s[`DBO_AL_HI:`DBO_AL_LO];
				o_al_reserved <= (addr_s[`DBO_AL_HI:`DBO_AL_LO] ==
					`DBO_AL_RESERVED);
				o_termination <= {addr_s[`DBO_BIT_RTT_HI],
					addr_s[`DBO_BIT_RTT_LO]};
				o_strobe_n_off <= addr_s[`DBO_BIT_STROBE_N_OFF];
				o_extra_read_strobe <= addr_s[`DBO_BIT_XSTROBE];
				o_driver_calibration_program <=
					addr_s[`DBO_CAL_HI:`DBO_CAL_LO];
				o_cal_reserved <= (addr_s[`DBO_CAL_HI:`DBO_CAL_LO] !=
					`DBO_CAL_EXIT) & (addr_s[`DBO_CAL_HI:`DBO_CAL_LO] !=
					`DBO_CAL_DEFAULT);
				o_outputs_off <= addr_s[`DBO_BIT_OUT_OFF];
			end else if (sr_entry) begin
				o_self_refresh <= 1'b1;
				o_dll_on <= 1'b0;
			end else if (sr_exit) begin
				o_self_refresh <= 1'b0;
				o_dll_on <= o_config_loaded &
					~o_config_word[`DBO_BIT_DLL_OFF];
			end
		end
	end

	// ---------------------------------------------
	// burst sequencer
	// ---------------------------------------------
	wire [2:0] col_calc;
	reg [2:0] beat;
	reg [2:0] start_q;
	reg len8_q;
	reg ilv_q;
	reg busy;
	dbo_order u_order (
		.i_len8(len8_q),
		.i_ilv(ilv_q),
		.i_start(start_q),
		.i_beat(beat),
		.o_col(col_calc)
	);
	wire last_beat = (len8_q == `DBO_BL8) ? (beat == 3'h7) :
		(beat == 3'h3);
	always @(posedge i_core_clk) begin
		if (i_rst) begin
			beat <= 3'h0;
			start_q <= 3'h0;
			len8_q <= 1'b0;
			ilv_q <= 1'b0;
			busy <= 1'b0;
			o_col <= 3'h0;
			o_col_valid <= 1'b0;
		end else begin
			o_col_valid <= busy;
			o_col <= col_calc;
			if (i_burst_start) begin
				// a new start cuts any running burst, as seamless bursts do
				start_q <= i_start_col;
				len8_q <= i_len8;
				ilv_q <= i_ilv;
				beat <= 3'h0;
				busy <= 1'b1;
			end else if (busy) begin
				beat <= beat + 3'h1;
				if (last_beat) begin
					busy <= 1'b0;
				end
			end
		end
	end
endmodule

/* tb/dbo_checker.sv */
// assertions on the burst and config word outputs
`timescale 1ns/10ps
module dbo_checker (
	input wire i_core_clk,
	input wire i_rst,
	input wire i_burst_start,
	input wire i_len8,
	input wire o_col_valid,
	input wire [13:0] o_config_word,
	input wire o_config_loaded,
	input wire o_dll_on,
	input wire o_self_refresh,
	input wire [2:0] o_additive_latency,
	input wire o_al_reserved,
	input wire [1:0] o_termination,
	input wire [2:0] o_driver_calibration_program,
	input wire o_cal_reserved,
	input wire o_outputs_off
);
default clocking @(posedge i_core_clk); endclocking
default disable iff (i_rst);
a_burst_start: assert property (i_burst_start |-> ##2 o_col_valid)
	else $error("burst did not start");
a_bl4_length: assert property ((i_burst_start && !i_len8) ##1
	!i_burst_start [*5] |=> !o_col_valid) else $error("bl4 too long");
a_bl8_length: assert property ((i_burst_start && i_len8) ##1
	!i_burst_start [*8] |=> ##1 !o_col_valid) else $error("bl8 too long");
a_al_field: assert property (o_additive_latency == o_config_word[5:3] &&
	o_al_reserved == (&o_config_word[5:3])) else $error("latency field");
a_term_field: assert property
	(o_termination == {o_config_word[6], o_config_word[2]})
	else $error("termination field");
a_cal_field: assert property (o_driver_calibration_program ==
	o_config_word[9:7] && o_cal_reserved == (|o_config_word[9:7] &&
	!(&o_config_word[9:7]))) else $error("calibration field");
a_out_off: assert property (o_outputs_off == o_config_word[12])
	else $error("output disable field");
a_dll_refresh: assert property (o_self_refresh |-> !o_dll_on)
	else $error("loop on in self refresh");
a_loaded_sticky: assert property (o_config_loaded |=> o_config_loaded)
	else $error("loaded flag dropped");
endmodule
bind dbo_top dbo_checker i_chk (
	.i_core_clk(i_core_clk),
	.i_rst(i_rst),
	.i_burst_start(i_burst_start),
	.i_len8(i_len8),
	.o_col_valid(o_col_valid),
	.o_config_word(o_config_word),
	.o_config_loaded(o_config_loaded),
	.o_dll_on(o_dll_on),
	.o_self_refresh(o_self_refresh),
	.o_additive_latency(o_additive_latency),
	.o_al_reserved(o_al_reserved),
	.o_termination(o_termination),
	.o_driver_calibration_program(o_driver_calibration_program),
	.o_cal_reserved(o_cal_reserved),
	.o_outputs_off(o_outputs_off)
);

/* tb/dbo_ctrl_model.sv */
// controller side model: link clock and command pins
`timescale 1ns/10ps
module dbo_ctrl_model (
	output logic o_link_clk,
	output logic o_cke,
	output logic [3:0] o_cmd,
	output logic [1:0] o_ba,
	output logic [13:0] o_addr
);
initial begin
	o_link_clk = 1'h0;
	o_cke = 1'h1;
	o_cmd = 4'hF;
	o_ba = 2'h0;
	o_addr = 14'h0000;
end
always #200 o_link_clk = ~o_link_clk;
// pins move on the falling edge, far from the sampled rising edge
// loop enabled by the first load with bit 0 clear; reads never issued
task automatic send(input logic k, input logic [3:0] c,
	input logic [1:0] b, input logic [13:0] a);
	@(negedge o_link_clk);
	o_cke <= k;
	o_cmd <= c;
	o_ba <= b;
	o_addr <= a;
	@(negedge o_link_clk);
	o_cmd <= 4'hF;
	o_ba <= ~b;
	o_addr <= ~a; // released bus shows no stale word
	repeat (2) @(negedge o_link_clk);
endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for burst order and config word one
`timescale 1ns/10ps
module tb_top;
logic i_core_clk = 1'h0;
logic i_rst = 1'h1;
logic i_burst_start = 1'h0;
logic i_len8 = 1'h0;
logic i_ilv = 1'h0;
logic [2:0] i_start_col = 3'h0;
wire i_link_clk, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n;
wire [3:0] cmd;
wire [1:0] i_ba, o_termination;
wire [13:0] i_addr, o_config_word;
wire [2:0] o_col, o_additive_latency, o_driver_calibration_program;
wire o_col_valid, o_config_loaded, o_dll_on, o_self_refresh;
wire o_drive_reduced, o_al_reserved, o_strobe_n_off, o_extra_read_strobe;
wire o_cal_reserved, o_outputs_off;
int n_fail = 0;
int check_count = 0;
assign {i_cs_n, i_ras_n, i_cas_n, i_we_n} = cmd;
dbo_top i_dut (
	.i_core_clk(i_core_clk),
	.i_rst(i_rst),
	.i_link_clk(i_link_clk),
	.i_cke(i_cke),
	.i_cs_n(i_cs_n),
	.i_ras_n(i_ras_n),
	.i_cas_n(i_cas_n),
	.i_we_n(i_we_n),
	.i_ba(i_ba),
	.i_addr(i_addr),
	.i_burst_start(i_burst_start),
	.i_len8(i_len8),
	.i_ilv(i_ilv),
	.i_start_col(i_start_col),
	.o_col(o_col),
	.o_col_valid(o_col_valid),
	.o_config_word(o_config_word),
	.o_config_loaded(o_config_loaded),
	.o_dll_on(o_dll_on),
	.o_self_refresh(o_self_refresh),
	.o_drive_reduced(o_drive_reduced),
	.o_additive_latency(o_additive_latency),
	.o_al_reserved(o_al_reserved),
	.o_termination(o_termination),
	.o_strobe_n_off(o_strobe_n_off),
	.o_extra_read_strobe(o_extra_read_strobe),
	.o_driver_calibration_program(o_driver_calibration_program),
	.o_cal_reserved(o_cal_reserved),
	.o_outputs_off(o_outputs_off)
);
dbo_ctrl_model i_ctrl (.o_link_clk(i_link_clk), .o_cke(i_cke),
	.o_cmd(cmd), .o_ba(i_ba), .o_addr(i_addr));
always #25 i_core_clk = ~i_core_clk;
// ----
// tasks
// ----
task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
	check_count++;
	if (seen !== exp) begin
		n_fail++;
		$display("Error at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic final_report;
	if (n_fail == 0 && check_count > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
task automatic burst(input logic l8, input logic il, input logic [2:0] s);
	logic [2:0] e;
	@(posedge i_core_clk);
	i_len8 <= l8;
	i_ilv <= il;
	i_start_col <= s;
	i_burst_start <= 1'h1;
	@(posedge i_core_clk);
	i_burst_start <= 1'h0;
	for (int b = 0; b < (l8 ? 8 : 4); b++) begin
		@(posedge i_core_clk);
		#1;
		e = il ? s ^ b[2:0] : {s[2] ^ b[2], s[1:0] + b[1:0]};
		chk(o_col_valid, 1'h1);
		chk(o_col, e);
	end
	@(posedge i_core_clk);
	#1;
	chk(o_col_valid, 1'h0);
endtask
task automatic fields(input logic [13:0] w, input logic sr);
	chk(o_config_word, w);
	chk(o_config_loaded, 1'h1);
	chk(o_dll_on, !w[0] && !sr);
	chk(o_self_refresh, sr);
	chk(o_drive_reduced, w[1]);
	chk(o_al_reserved, &w[5:3]);
	chk(o_additive_latency, w[5:3]);
	chk(o_driver_calibration_program, w[9:7]);
	chk(o_outputs_off, w[12]);
	chk(o_termination, {w[6], w[2]});
	chk(o_strobe_n_off, w[10]);
	chk(o_extra_read_strobe, w[11]);
	chk(o_cal_reserved, (|w[9:7]) && !(&w[9:7]));
endtask
// ----
// sequence; hang guard counts as a mismatch
// ----
initial begin
	#2000000;
	n_fail++;
	final_report;
end
initial begin
	logic [13:0] w [3] = '{14'h1FFF, 14'h0254, 14'h0000};
	repeat (3) @(posedge i_core_clk);
	i_rst <= 1'h0;
	for (int i = 0; i < 32; i++)
		burst(i[4], i[3], i[2:0]);
	chk(o_config_loaded, 1'h0);
	chk(o_dll_on, 1'h0);
	foreach (w[i]) begin
		i_ctrl.send(1'h1, 4'h0, 2'h1, w[i]);
		fields(w[i], 1'h0);
	end
	i_ctrl.send(1'h1, 4'h0, 2'h0, 14'h1FFF);
	fields(14'h0000, 1'h0);
	i_ctrl.send(1'h0, 4'h1, 2'h0, 14'h0000);
	fields(14'h0000, 1'h1);
	i_ctrl.send(1'h1, 4'hF, 2'h0, 14'h0000);
	fields(14'h0000, 1'h0);
	final_report;
end
endmodule
